// ---- rtl/txcwd_pad.sv ----
// pad counter: filler dwords that follow a buffer
`timescale 1ns/1ns
`default_nettype none
module txcwd_pad
    import txcwd_pkg::*;
(
    // command fields
    input  wire logic [1:0]  align,
    input  wire logic [4:0]  ofs,
    input  wire logic [10:0] size,
    // results
    output logic      [9:0]  data_dw,
    output logic      [3:0]  fill_dw
);
    logic [11:0] span;
    logic [9:0]  used;
    logic [2:0]  blk;
    always_comb begin
        span    = 12'(size) + 12'(ofs) + 12'h003;
        used    = span[11:2];
        data_dw = used;
        case (align)
            ALIGN_16: blk = 3'h3;
            ALIGN_32: blk = 3'h7;
            default:  blk = 3'h0;
        endcase
        // dwords from data end up to next aligned block
        fill_dw = 4'((~used[2:0] + 3'h1) & blk);
    end
endmodule : txcwd_pad
`default_nettype wire

// ---- rtl/txcwd_pkg.sv ----
// package: field layout, register map and types of the tx command decoder
package txcwd_pkg;
    // ==========================================================
    // first command word fields
    localparam int CMDA_DONE_BIT  = 31;
    localparam int CMDA_ALIGN_HI  = 25;
    localparam int CMDA_ALIGN_LO  = 24;
    localparam int CMDA_OFS_HI    = 20;
    localparam int CMDA_OFS_LO    = 16;
    localparam int CMDA_FIRST_BIT = 13;
    localparam int CMDA_LAST_BIT  = 12;
    localparam int CMDA_SIZE_HI   = 10;
    localparam int CMDA_SIZE_LO   = 0;
    // ==========================================================
    // second command word fields
    localparam int CMDB_TAG_HI    = 31;
    localparam int CMDB_TAG_LO    = 16;
    localparam int CMDB_CSUM_BIT  = 14;
    localparam int CMDB_NOCRC_BIT = 13;
    localparam int CMDB_NOPAD_BIT = 12;
    localparam int CMDB_LEN_HI    = 10;
    localparam int CMDB_LEN_LO    = 0;
    // ==========================================================
    // end alignment codes
    localparam logic [1:0] ALIGN_4  = 2'h0;
    localparam logic [1:0] ALIGN_16 = 2'h1;
    localparam logic [1:0] ALIGN_32 = 2'h2;
    // ==========================================================
    // apb register byte addresses
    localparam logic [7:0] REG_CTRL   = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_MASK   = 8'h08;
    localparam logic [7:0] REG_TAG    = 8'h0C;
    localparam logic [7:0] REG_COUNT  = 8'h10;
    // ==========================================================
    // status bits and reset values
    localparam int ST_DONE = 0;
    localparam int ST_ERR  = 1;
    localparam int ST_PKT  = 2;
    localparam int NUM_EV  = 3;
    localparam logic [31:0] ZERO_WORD  = 32'h0000_0000;
    localparam logic [10:0] ZERO_COUNT = 11'h000;
    localparam logic [2:0]  ZERO_EV    = 3'h0;
    // ==========================================================
    // per packet control handed to the mac path
    typedef struct packed {
        logic [15:0] tag;
        logic        csum_en;
        logic        add_crc;
        logic        add_pad;
        logic [4:0]  ofs;
        logic        first;
        logic        last;
    } txcwd_ctl_t;
    // one 32-bit stream beat
    typedef struct packed {
        logic [31:0] data;
        logic        valid;
    } txcwd_beat_t;
endpackage : txcwd_pkg

// ---- rtl/txcwd_sum.sv ----
// length accumulator across the segments of one packet
`timescale 1ns/1ns
`default_nettype none
module txcwd_sum
    import txcwd_pkg::*;
(
    // clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // segment events
    input  wire logic        seg_stb,
    input  wire logic        first,
    input  wire logic [10:0] size,
    // running total
    output logic      [11:0] total_r,
    output logic      [11:0] total_nxt
);
    always_comb begin
        total_nxt = first ? 12'(size) : total_r + 12'(size);
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            total_r <= 12'h000;
        end else if (seg_stb) begin
            total_r <= total_nxt;
        end
    end
endmodule : txcwd_sum
`default_nettype wire

// ---- rtl/txcwd_top.sv ----
// tx command word decoder with apb control and status
`timescale 1ns/1ns
`default_nettype none
// Overview of operation
// - byte offset from word one bits 20:16
// - word one bits 10:0 give buffer bytes
// - size, offset and alignment give filler dwords, dropped
// - summed sizes mismatch length sets error flag
// - tag copied to tag register unchanged
// - checksum needs request, first segment, engine enable
// - word two bit 13 disables crc append
// - word two bit 12 suppresses short frame padding
// - padding suppressed by word two still forces crc append
// - alignment field bits 25:24 selects 4/16/32
// - word one bit 31 raises buffer loaded flag
// - word one, word two, then buffer data
module txcwd_top
    import txcwd_pkg::*;
(
    // apb
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // transmit fifo stream in
    input  wire logic [31:0] in_data,
    input  wire logic        in_valid,
    output logic             in_ready,
    // stripped data out
    output logic      [31:0] out_data,
    output logic             out_valid,
    output logic             out_last,
    // per packet control
    output txcwd_ctl_t       ctl,
    output logic             ctl_valid,
    // flags
    output logic             buffer_loaded_flag,
    output logic             transmit_error_flag,
    output logic             irq
);
    // ==========================================================
    // state
    typedef enum logic [2:0] {
        S_CMDA, S_CMDB, S_SKIP, S_DATA, S_FILL
    } txcwd_state_t;

    txcwd_state_t state_r;
    logic [31:0]  cmda_r;
    logic [31:0]  cmdb_r;
    logic [9:0]   left_r;
    logic [3:0]   fill_r;
    logic [2:0]   skip_r;
    logic [31:0]  cmdb_now;
    logic         tx_checksum_engine_enable;
    logic         ctrl_nopad_r;
    logic [31:0]  ctrl_r;
    logic [2:0]   stat_r;
    logic [2:0]   mask_r;
    logic [15:0]  tag_r;
    logic [10:0]  cnt_r;
    logic [2:0]   ev;
    logic [9:0]   data_dw;
    logic [3:0]   fill_dw;
    logic [11:0]  total_r;
    logic [11:0]  total_nxt;
    logic         take;
    logic         seg_stb;
    logic         seg_end;
    logic         apb_acc;
    logic         apb_wr;
    logic         apb_rd;

    assign take    = in_valid && in_ready;
    assign apb_acc = psel && penable;
    assign apb_wr  = apb_acc && pwrite;
    assign apb_rd  = apb_acc && !pwrite;
    assign tx_checksum_engine_enable = ctrl_r[0];
    assign ctrl_nopad_r = ctrl_r[1];

    // ==========================================================
    // filler and length helpers
    // byte count into helpers
    txcwd_pad u_pad (
        .align   (cmda_r[CMDA_ALIGN_HI:CMDA_ALIGN_LO]),
        .ofs     (cmda_r[CMDA_OFS_HI:CMDA_OFS_LO]),
        .size    (cmda_r[CMDA_SIZE_HI:CMDA_SIZE_LO]),
        .data_dw (data_dw),
        .fill_dw (fill_dw)
    );

    txcwd_sum u_sum (
        .pclk      (pclk),
        .presetn   (presetn),
        .seg_stb   (seg_stb),
        .first     (cmda_r[CMDA_FIRST_BIT]),
        .size      (cmda_r[CMDA_SIZE_HI:CMDA_SIZE_LO]),
        .total_r   (total_r),
        .total_nxt (total_nxt)
    );

    // ==========================================================
    // buffer sequencer
    // two command words then data
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r <= S_CMDA;
            cmda_r  <= ZERO_WORD;
            cmdb_r  <= ZERO_WORD;
            left_r  <= 10'h000;
            fill_r  <= 4'h0;
            skip_r  <= 3'h0;
        end else if (take) begin
            case (state_r)
                S_CMDA: begin
                    cmda_r  <= in_data;
                    state_r <= S_CMDB;
                end
                S_CMDB: begin
                    cmdb_r <= in_data;
                    // whole-dword part of the offset skipped
                    skip_r <= cmda_r[CMDA_OFS_HI:CMDA_OFS_LO+2];
                    left_r <= data_dw - 10'(cmda_r[CMDA_OFS_HI:CMDA_OFS_LO+2]);
                    fill_r <= fill_dw;
                    if (cmda_r[CMDA_OFS_HI:CMDA_OFS_LO+2] != 3'h0)
                        state_r <= S_SKIP;
                    else if (data_dw != 10'h000)
                        state_r <= S_DATA;
                    else if (fill_dw != 4'h0)
                        state_r <= S_FILL;
                    else
                        state_r <= S_CMDA;
                end
                S_SKIP: begin
                    skip_r <= skip_r - 3'h1;
                    if (skip_r == 3'h1) begin
                        if (left_r != 10'h000)
                            state_r <= S_DATA;
                        else if (fill_r != 4'h0)
                            state_r <= S_FILL;
                        else
                            state_r <= S_CMDA;
                    end
                end
                S_DATA: begin
                    left_r <= left_r - 10'h001;
                    if (left_r == 10'h001)
                        state_r <= (fill_r != 4'h0) ? S_FILL : S_CMDA;
                end
                S_FILL: begin
                    fill_r <= fill_r - 4'h1;
                    if (fill_r == 4'h1)
                        state_r <= S_CMDA;
                end
                default: state_r <= S_CMDA;
            endcase
        end
    end

    assign seg_end = take && (
        (state_r == S_DATA && left_r == 10'h001 && fill_r == 4'h0) ||
        (state_r == S_FILL && fill_r == 4'h1) ||
        (state_r == S_SKIP && skip_r == 3'h1 && left_r == 10'h000 &&
         fill_r == 4'h0) ||
        (state_r == S_CMDB && data_dw == 10'h000 && fill_dw == 4'h0 &&
         cmda_r[CMDA_OFS_HI:CMDA_OFS_LO+2] == 3'h0));
    assign seg_stb = seg_end;

    // ==========================================================
    // stream outputs
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            out_data  <= ZERO_WORD;
            out_valid <= 1'b0;
            out_last  <= 1'b0;
            in_ready  <= 1'b0;
        end else begin
            in_ready  <= 1'b1;
            out_valid <= take && state_r == S_DATA;
            out_last  <= take && state_r == S_DATA && left_r == 10'h001 &&
                         cmda_r[CMDA_LAST_BIT];
            if (take && state_r == S_DATA)
                out_data <= in_data;
        end
    end

    // ==========================================================
    // per packet control decode
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctl       <= '0;
            ctl_valid <= 1'b0;
        end else begin
            ctl_valid <= take && state_r == S_CMDB;
            if (take && state_r == S_CMDB) begin
                ctl.tag     <= in_data[CMDB_TAG_HI:CMDB_TAG_LO];
                ctl.csum_en <= in_data[CMDB_CSUM_BIT] &&
                               cmda_r[CMDA_FIRST_BIT] &&
                               tx_checksum_engine_enable;
                // crc off only when word two bit 12 is clear
                ctl.add_crc <= !in_data[CMDB_NOCRC_BIT] ||
                               in_data[CMDB_NOPAD_BIT];
                ctl.add_pad <= !in_data[CMDB_NOPAD_BIT] && !ctrl_nopad_r;
                ctl.ofs     <= cmda_r[CMDA_OFS_HI:CMDA_OFS_LO];
                ctl.first   <= cmda_r[CMDA_FIRST_BIT];
                ctl.last    <= cmda_r[CMDA_LAST_BIT];
            end
        end
    end

    // ==========================================================
    // events, length check
    // word two as it arrives, for buffers with no data
    assign cmdb_now = (state_r == S_CMDB) ? in_data : cmdb_r;

    always_comb begin
        ev = ZERO_EV;
        ev[ST_DONE] = seg_end && cmda_r[CMDA_DONE_BIT];
        ev[ST_ERR]  = seg_end && cmda_r[CMDA_LAST_BIT] &&
                      total_nxt != 12'(cmdb_now[CMDB_LEN_HI:CMDB_LEN_LO]);
        ev[ST_PKT]  = seg_end && cmda_r[CMDA_LAST_BIT];
    end

    // ==========================================================
    // apb registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_r <= ZERO_WORD;
            mask_r <= ZERO_EV;
        end else if (apb_wr) begin
            if (paddr == REG_CTRL)
                ctrl_r <= {30'h0000_0000, pwdata[1:0]};
            if (paddr == REG_MASK)
                mask_r <= pwdata[NUM_EV-1:0];
        end
    end

    // sticky status, set wins over write-one clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stat_r <= ZERO_EV;
        end else begin
            stat_r <= (stat_r & ~((apb_wr && paddr == REG_STATUS) ?
                       pwdata[NUM_EV-1:0] : ZERO_EV)) | ev;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tag_r <= 16'h0000;
            cnt_r <= ZERO_COUNT;
        end else begin
            if (ev[ST_PKT])
                tag_r <= cmdb_now[CMDB_TAG_HI:CMDB_TAG_LO];
            if (seg_stb)
                cnt_r <= 11'(total_nxt);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= ZERO_WORD;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel && !penable;
            pslverr <= psel && !penable &&
                       !(paddr == REG_CTRL || paddr == REG_STATUS ||
                         paddr == REG_MASK || paddr == REG_TAG ||
                         paddr == REG_COUNT);
            if (psel && !penable && !pwrite) begin
                case (paddr)
                    REG_CTRL:   prdata <= ctrl_r;
                    REG_STATUS: prdata <= {29'h0000_0000, stat_r};
                    REG_MASK:   prdata <= {29'h0000_0000, mask_r};
                    REG_TAG:    prdata <= {16'h0000, tag_r};
                    REG_COUNT:  prdata <= {21'h00_0000, cnt_r};
                    default:    prdata <= ZERO_WORD;
                endcase
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            buffer_loaded_flag  <= 1'b0;
            transmit_error_flag <= 1'b0;
            irq                 <= 1'b0;
        end else begin
            buffer_loaded_flag  <= ev[ST_DONE];
            transmit_error_flag <= ev[ST_ERR];
            irq                 <= |(stat_r & mask_r);
        end
    end

    // ==========================================================
    // checks
    sequence s_cmdb_take;
        take && state_r == S_CMDB;
    endsequence

    csum_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
        s_cmdb_take |=> ctl.csum_en == ($past(in_data[CMDB_CSUM_BIT]) &&
        $past(cmda_r[CMDA_FIRST_BIT]) && $past(tx_checksum_engine_enable)))
        else $error("checksum enable wrong");
    crc_forced_a: assert property (@(posedge pclk) disable iff (!presetn)
        s_cmdb_take ##0 in_data[CMDB_NOPAD_BIT] |=> ctl.add_crc)
        else $error("crc not forced");
    crc_off_a: assert property (@(posedge pclk) disable iff (!presetn)
        s_cmdb_take ##0 (in_data[CMDB_NOCRC_BIT] && !in_data[CMDB_NOPAD_BIT])
        |=> !ctl.add_crc) else $error("crc not disabled");
    pad_off_a: assert property (@(posedge pclk) disable iff (!presetn)
        s_cmdb_take ##0 in_data[CMDB_NOPAD_BIT] |=> !ctl.add_pad)
        else $error("pad not suppressed");
    tag_copy_a: assert property (@(posedge pclk) disable iff (!presetn)
        s_cmdb_take |=> ctl.tag == $past(in_data[CMDB_TAG_HI:CMDB_TAG_LO]))
        else $error("tag not copied");
    len_err_a: assert property (@(posedge pclk) disable iff (!presetn)
        ev[ST_ERR] |=> transmit_error_flag && stat_r[ST_ERR])
        else $error("length error not flagged");
    done_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
        seg_end && cmda_r[CMDA_DONE_BIT] |=> buffer_loaded_flag)
        else $error("loaded flag missing");
    fill_drop_a: assert property (@(posedge pclk) disable iff (!presetn)
        take && state_r == S_FILL |=> !out_valid)
        else $error("filler forwarded");
    word_order_a: assert property (@(posedge pclk) disable iff (!presetn)
        take && state_r == S_CMDA |=> state_r == S_CMDB)
        else $error("command order broken");
endmodule : txcwd_top
`default_nettype wire

// ---- tb/tb.sv ----
// testbench: tx command decoder fed by the host stream model
`timescale 1ns/1ns
`default_nettype none
module tb
    import txcwd_pkg::*;
;
    // ==========================================================
    // signals
    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [31:0] in_data;
    logic        in_valid;
    logic        in_ready;
    logic [31:0] out_data;
    logic        out_valid;
    logic        out_last;
    txcwd_ctl_t  ctl;
    logic        ctl_valid;
    logic        loaded;
    logic        txerr;
    logic        irq;
    logic        irq_s;
    logic [31:0] q;
    logic        e;
    int          bad_count;
    int          check_count;
    int          n_done;
    int          n_err;
    int          last_at;
    logic [31:0] oq[$];
    txcwd_ctl_t  cq[$];
    // ==========================================================
    // clock, design and host
    initial pclk = 1'b0;
    always #25 pclk = ~pclk;
    txcwd_top dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .in_data(in_data),
        .in_valid(in_valid), .in_ready(in_ready), .out_data(out_data),
        .out_valid(out_valid), .out_last(out_last), .ctl(ctl),
        .ctl_valid(ctl_valid), .buffer_loaded_flag(loaded),
        .transmit_error_flag(txerr), .irq(irq)
    );
    txcwd_host_model host (
        .pclk(pclk), .in_ready(in_ready), .in_data(in_data),
        .in_valid(in_valid)
    );
    // ==========================================================
    // output monitor, sampled mid cycle
    always @(negedge pclk) begin
        irq_s = irq;
        if (out_valid === 1'b1) oq.push_back(out_data);
        if (out_last === 1'b1) last_at = oq.size();
        if (ctl_valid === 1'b1) cq.push_back(ctl);
        if (loaded === 1'b1) n_done++;
        if (txerr === 1'b1) n_err++;
    end
    // ==========================================================
    // helpers
    task automatic chk(input string nm, input logic [31:0] s, x);
        check_count++;
        if (s !== x) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", nm, x, s);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb
    function automatic logic [31:0] cmd_a(input logic dn,
        input logic [1:0] al, input logic [4:0] of, input logic fi, la,
        input logic [10:0] sz);
        return {dn, 5'h00, al, 3'h0, of, 2'h0, fi, la, 1'h0, sz};
    endfunction : cmd_a
    // packet length and a free tag in word two
    function automatic logic [31:0] cmd_b(input logic [15:0] tg,
        input logic cs, nc, np, input logic [10:0] ln);
        return {tg, 1'h0, cs, nc, np, 1'h0, ln};
    endfunction : cmd_b
    task automatic chk_out(input int at, input logic [31:0] b, input int n);
        for (int i = 0; i < n; i++) chk("word", oq[at + i], b + 32'(i));
    endtask : chk_out
    task automatic clr();
        oq.delete();
        cq.delete();
        n_done  = 0;
        n_err   = 0;
        last_at = 0;
    endtask : clr
    // ==========================================================
    // scenarios
    task automatic t_regs();
        logic [7:0] r[5];
        r = '{REG_CTRL, REG_STATUS, REG_MASK, REG_TAG, REG_COUNT};
        for (int i = 0; i < 5; i++) begin
            apb(1'b0, r[i], ZERO_WORD);
            chk("reset value", q, ZERO_WORD);
            chk("slverr", 32'(e), 32'h0);
        end
        apb(1'b1, 8'h14, 32'hFFFF_FFFF);
        chk("unmapped wr", 32'(e), 32'h1);
        apb(1'b0, 8'h14, ZERO_WORD);
        chk("unmapped rd", 32'(e), 32'h1);
        chk("unmapped data", q, ZERO_WORD);
        $display("test regs done");
    endtask : t_regs
    task automatic t_single();
        clr();
        apb(1'b1, REG_CTRL, 32'h0000_0001);
        host.send_buf(cmd_a(1'b1, ALIGN_16, 5'h05, 1'b1, 1'b1, 11'h00D),
            cmd_b(16'hBEEF, 1'b1, 1'b1, 1'b0, 11'h00D), 32'hA000_0000, 0);
        repeat (4) @(posedge pclk);
        chk("words", 32'(oq.size()), 32'h4);
        chk_out(0, 32'hA000_0001, 4);
        chk("last", 32'(last_at), 32'h4);
        chk("ctl n", 32'(cq.size()), 32'h1);
        chk("ctl", 32'(cq[0]), 32'({16'hBEEF, 3'h5, 5'h05, 2'h3}));
        chk("done", 32'(n_done), 32'h1);
        chk("error", 32'(n_err), 32'h0);
        apb(1'b0, REG_STATUS, ZERO_WORD);
        chk("status", q, 32'h0000_0005);
        apb(1'b0, REG_COUNT, ZERO_WORD);
        chk("sum", q, 32'h0000_000D);
        apb(1'b0, REG_TAG, ZERO_WORD);
        chk("tag", q, 32'h0000_BEEF);
        $display("test single done");
    endtask : t_single
    task automatic t_multi();
        clr();
        apb(1'b1, REG_STATUS, 32'h0000_0007);
        apb(1'b1, REG_CTRL, 32'h0000_0002);
        host.send_buf(cmd_a(1'b0, ALIGN_32, 5'h00, 1'b1, 1'b0, 11'h004),
            cmd_b(16'h1234, 1'b1, 1'b0, 1'b0, 11'h00A), 32'hB000_0000, 2);
        host.send_buf(cmd_a(1'b0, ALIGN_4, 5'h03, 1'b0, 1'b1, 11'h005),
            cmd_b(16'h5678, 1'b1, 1'b1, 1'b1, 11'h00A), 32'hC000_0000, 2);
        repeat (4) @(posedge pclk);
        chk("words", 32'(oq.size()), 32'h3);
        chk_out(0, 32'hB000_0000, 1);
        chk_out(1, 32'hC000_0000, 2);
        chk("last", 32'(last_at), 32'h3);
        chk("ctl a", 32'(cq[0]), 32'({16'h1234, 3'h2, 5'h00, 2'h2}));
        chk("ctl b", 32'(cq[1]), 32'({16'h5678, 3'h2, 5'h03, 2'h1}));
        chk("error", 32'(n_err), 32'h1);
        chk("done", 32'(n_done), 32'h0);
        apb(1'b0, REG_STATUS, ZERO_WORD);
        chk("status", q, 32'h0000_0006);
        chk("irq masked", 32'(irq_s), 32'h0);
        apb(1'b1, REG_MASK, 32'h0000_0002);
        @(posedge pclk);
        chk("irq set", 32'(irq_s), 32'h1);
        apb(1'b1, REG_STATUS, 32'h0000_0002);
        @(posedge pclk);
        chk("irq clear", 32'(irq_s), 32'h0);
        apb(1'b0, REG_STATUS, ZERO_WORD);
        chk("status w1c", q, 32'h0000_0004);
        apb(1'b0, REG_COUNT, ZERO_WORD);
        chk("sum", q, 32'h0000_0009);
        apb(1'b0, REG_TAG, ZERO_WORD);
        chk("tag", q, 32'h0000_5678);
        $display("test multi done");
    endtask : t_multi
    // ==========================================================
    // verdict and main sequence
    task automatic test_done();
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : test_done
    initial begin
        repeat (3000) @(posedge pclk);
        bad_count++;
        test_done();
    end
    initial begin
        presetn     = 1'b0;
        psel        = 1'b0;
        penable     = 1'b0;
        pwrite      = 1'b0;
        paddr       = 8'h00;
        pwdata      = ZERO_WORD;
        bad_count   = 0;
        check_count = 0;
        clr();
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        repeat (2) @(posedge pclk);
        t_regs();
        t_single();
        t_multi();
        test_done();
    end
endmodule : tb
`default_nettype wire

// ---- tb/txcwd_host_model.sv ----
// host model: writes transmit buffers into the decoder stream
`timescale 1ns/1ns
`default_nettype none
module txcwd_host_model
    import txcwd_pkg::*;
(
    // clock
    input  wire logic        pclk,
    // transmit fifo stream
    input  wire logic        in_ready,
    output logic      [31:0] in_data,
    output logic             in_valid
);
    initial begin
        in_data  = ZERO_WORD;
        in_valid = 1'b0;
    end
    // ==========================================================
    // one word, held until taken
    task automatic put(input logic [31:0] w, input int gap);
        in_data  <= w;
        in_valid <= 1'b1;
        do @(posedge pclk); while (in_ready !== 1'b1);
        if (gap > 0) begin
            in_valid <= 1'b0;
            // released line shows no stale word
            in_data  <= ~w;
            repeat (gap) @(posedge pclk);
        end
    endtask : put
    // ==========================================================
    // whole buffer: commands, offset, data, filler
    task automatic send_buf(input logic [31:0] w1, w2, base,
                            input int gap);
        int tot;
        int al;
        int n;
        tot = int'(w1[10:0]) + int'(w1[20:16]) + 3;
        tot = tot / 4;
        // filler up to the chosen alignment
        al  = (w1[25:24] == ALIGN_16) ? 4 : (w1[25:24] == ALIGN_32) ? 8 : 1;
        n   = (tot + al - 1) / al * al;
        // both command words lead the data
        put(w1, gap);
        put(w2, gap);
        for (int i = 0; i < n; i++) put(base + 32'(i), gap);
        if (gap == 0) begin
            in_valid <= 1'b0;
            in_data  <= ~in_data;
            @(posedge pclk);
        end
    endtask : send_buf
endmodule : txcwd_host_model
`default_nettype wire
